/* File: asalu_consts.svh */
// Offsets, field positions, reset values and opcodes of the ALU block
`ifndef ASALU_CONSTS_SVH
`define ASALU_CONSTS_SVH

`define ASALU_ADR_ACCUM     12'h000
`define ASALU_ADR_STATUS    12'h004
`define ASALU_ADR_PTR0      12'h008
`define ASALU_ADR_PTR1      12'h00C
`define ASALU_ADR_EXEC      12'h010
`define ASALU_ADR_RESULT    12'h014
`define ASALU_MEM_REGION    3'h2

`define ASALU_ST_C          0
`define ASALU_ST_DC         1
`define ASALU_ST_Z          2

`define ASALU_CMD_OP_LSB    0
`define ASALU_CMD_D         3
`define ASALU_CMD_N         4
`define ASALU_CMD_K_LSB     8
`define ASALU_CMD_F_LSB     16
`define ASALU_CMD_BUSY      31

`define ASALU_ACCUM_RST     8'h00
`define ASALU_FLAG_RST      1'b0
`define ASALU_PTR_RST       16'h0000
`define ASALU_CMD_RST       8'h00

`define ASALU_OPC_PTR_ADD   3'h1
`define ASALU_OPC_AND_LIT   3'h2
`define ASALU_OPC_ADD_LIT   3'h3
`define ASALU_OPC_AND_REG   3'h4
`define ASALU_OPC_ADD_REG   3'h5
`define ASALU_OPC_SHR       3'h6
`define ASALU_OPC_ADDC      3'h7

`define ASALU_PTR_MAX       16'hFFFF

`endif

/* File: asalu_pkg.sv */
// Types shared by the ALU block
package asalu_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_EXEC
    } asalu_state_e;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_POINTER_ADD_LITERAL,
        OP_AND_LITERAL_ACCUM,
        OP_ADD_LITERAL_ACCUM,
        OP_AND_ACCUM_REGISTER,
        OP_ADD_ACCUM_REGISTER,
        OP_ARITH_SHIFT_RIGHT,
        OP_ADD_WITH_CARRY_REGISTER
    } asalu_op_e;

endpackage : asalu_pkg

/* File: asalu_filemem.sv */
// File register memory with registered read data
`timescale 1ns/1ps

module asalu_filemem #(
    parameter int DEPTH = 128,
    parameter int WIDTH = 8
) (
    // Clock
    input  wire logic                     clk_sys,
    // Single port
    input  wire logic [$clog2(DEPTH)-1:0] addr,
    input  wire logic                     we,
    input  wire logic [WIDTH-1:0]         wdata,
    output logic      [WIDTH-1:0]         rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Read returns the old word on a write, one port only
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule : asalu_filemem

/* File: asalu_top.sv */
// Accumulator, pointer and file register ALU with a Wishbone slave
`timescale 1ns/1ps
`include "asalu_consts.svh"

module asalu_top #(
    parameter int FILE_DEPTH = 128
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Status
    output logic             busy,
    output logic             carry_flag,
    output logic             digit_carry_flag,
    output logic             zero_flag
);

    localparam int FW = $clog2(FILE_DEPTH);

    // Sum with carry out of bit 3 and bit 7
    function automatic logic [9:0] asalu_add8(input logic [7:0] a,
                                              input logic [7:0] b,
                                              input logic       cin);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        return {hi[4], lo[4], hi[3:0], lo[3:0]};
    endfunction : asalu_add8

    function automatic asalu_pkg::asalu_op_e asalu_decode(input logic [2:0] c);
        case (c)
            `ASALU_OPC_PTR_ADD: return asalu_pkg::OP_POINTER_ADD_LITERAL;
            `ASALU_OPC_AND_LIT: return asalu_pkg::OP_AND_LITERAL_ACCUM;
            `ASALU_OPC_ADD_LIT: return asalu_pkg::OP_ADD_LITERAL_ACCUM;
            `ASALU_OPC_AND_REG: return asalu_pkg::OP_AND_ACCUM_REGISTER;
            `ASALU_OPC_ADD_REG: return asalu_pkg::OP_ADD_ACCUM_REGISTER;
            `ASALU_OPC_SHR:     return asalu_pkg::OP_ARITH_SHIFT_RIGHT;
            `ASALU_OPC_ADDC:    return asalu_pkg::OP_ADD_WITH_CARRY_REGISTER;
            default:            return asalu_pkg::OP_NONE;
        endcase
    endfunction : asalu_decode

    asalu_pkg::asalu_state_e state;
    asalu_pkg::asalu_op_e    cmd_op;
    logic                    cmd_d;
    logic                    cmd_n;
    logic [7:0]              cmd_k;
    logic [FW-1:0]           cmd_f;
    logic [7:0]              accum;
    logic [15:0]             ptr0;
    logic [15:0]             ptr1;
    logic [7:0]              last_res;
    logic                    mem_rd_wait;
    logic [7:0]              mem_rdata;

    logic                    req;
    logic                    is_mem;
    logic                    ack_set;
    logic                    wr_go;
    logic                    start;
    logic                    exec_go;
    logic [31:0]             next_dat;
    logic [FW-1:0]           mem_addr;
    logic                    mem_we;
    logic [7:0]              mem_wdata;

    logic [9:0]              sum_lit;
    logic [9:0]              sum_reg;
    logic [9:0]              sum_cry;
    logic [15:0]             k_sext;
    logic [7:0]              next_res;
    logic                    next_c;
    logic                    next_dc;
    logic                    upd_c;
    logic                    upd_dc;
    logic                    upd_z;
    logic                    to_file;
    logic                    to_accum;

    assign busy = (state != asalu_pkg::ST_IDLE);

    // Bus stalls while an operation runs, so no write races the engine
    assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~busy;
    assign is_mem  = (wb_adr_i[11:9] == `ASALU_MEM_REGION);
    // Memory reads wait one cycle for the registered read data
    assign ack_set = req & (~is_mem | wb_we_i | mem_rd_wait);
    assign wr_go   = ack_set & wb_we_i;
    assign start   = wr_go & (wb_adr_i == `ASALU_ADR_EXEC);
    assign exec_go = (state == asalu_pkg::ST_EXEC);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mem_rd_wait <= 1'b0;
        end else begin
            mem_rd_wait <= req & is_mem & ~wb_we_i & ~mem_rd_wait;
        end
    end

    always_comb begin
        next_dat = 32'h0000_0000;
        if (is_mem) begin
            next_dat = {24'h00_0000, mem_rdata};
        end else begin
            case (wb_adr_i)
                `ASALU_ADR_ACCUM:  next_dat = {24'h00_0000, accum};
                `ASALU_ADR_STATUS: next_dat = {29'h0000_0000, zero_flag,
                                               digit_carry_flag, carry_flag};
                `ASALU_ADR_PTR0:   next_dat = {16'h0000, ptr0};
                `ASALU_ADR_PTR1:   next_dat = {16'h0000, ptr1};
                `ASALU_ADR_EXEC: begin
                    next_dat[`ASALU_CMD_BUSY] = busy;
                    next_dat[`ASALU_CMD_OP_LSB +: 3] = cmd_op;
                    next_dat[`ASALU_CMD_D] = cmd_d;
                    next_dat[`ASALU_CMD_N] = cmd_n;
                    next_dat[`ASALU_CMD_K_LSB +: 8] = cmd_k;
                    next_dat[`ASALU_CMD_F_LSB +: FW] = cmd_f;
                end
                `ASALU_ADR_RESULT: next_dat = {24'h00_0000, last_res};
                default:           next_dat = 32'h0000_0000;
            endcase
        end
    end

    // Unmapped addresses still answer, with zero data
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= ack_set;
            wb_dat_o <= (ack_set & ~wb_we_i) ? next_dat : 32'h0000_0000;
        end
    end

    // Command capture
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cmd_op <= asalu_pkg::OP_NONE;
            cmd_d  <= 1'b0;
            cmd_n  <= 1'b0;
            cmd_k  <= `ASALU_CMD_RST;
            cmd_f  <= '0;
        end else if (start) begin
            cmd_op <= asalu_decode(wb_dat_i[`ASALU_CMD_OP_LSB +: 3]);
            cmd_d  <= wb_dat_i[`ASALU_CMD_D];
            cmd_n  <= wb_dat_i[`ASALU_CMD_N];
            cmd_k  <= wb_dat_i[`ASALU_CMD_K_LSB +: 8];
            cmd_f  <= wb_dat_i[`ASALU_CMD_F_LSB +: FW];
        end
    end

    // Fixed two clocks per instruction cycle: operand fetch, execute
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= asalu_pkg::ST_IDLE;
        end else begin
            case (state)
                asalu_pkg::ST_IDLE:  state <= start ? asalu_pkg::ST_FETCH
                                                    : asalu_pkg::ST_IDLE;
                asalu_pkg::ST_FETCH: state <= asalu_pkg::ST_EXEC;
                asalu_pkg::ST_EXEC:  state <= asalu_pkg::ST_IDLE;
                default:             state <= asalu_pkg::ST_IDLE;
            endcase
        end
    end

    assign mem_addr  = busy ? cmd_f : wb_adr_i[FW+1:2];
    assign mem_we    = (exec_go & to_file) | (wr_go & is_mem & wb_sel_i[0]);
    assign mem_wdata = exec_go ? next_res : wb_dat_i[7:0];

    asalu_filemem #(
        .DEPTH (FILE_DEPTH),
        .WIDTH (8)
    ) u_filemem (
        .clk_sys (clk_sys),
        .addr    (mem_addr),
        .we      (mem_we),
        .wdata   (mem_wdata),
        .rdata   (mem_rdata)
    );

    assign sum_lit = asalu_add8(accum, cmd_k, 1'b0);
    assign sum_reg = asalu_add8(accum, mem_rdata, 1'b0);
    assign sum_cry = asalu_add8(accum, mem_rdata,
                                carry_flag);
    assign k_sext  = {{10{cmd_k[5]}}, cmd_k[5:0]};

    always_comb begin
        next_res = 8'h00;
        next_c   = carry_flag;
        next_dc  = digit_carry_flag;
        upd_c    = 1'b0;
        upd_dc   = 1'b0;
        upd_z    = 1'b0;
        to_file  = 1'b0;
        to_accum = 1'b0;
        case (cmd_op)
            asalu_pkg::OP_AND_LITERAL_ACCUM: begin
                next_res = accum & cmd_k;
                to_accum = 1'b1;
                upd_z    = 1'b1;
            end
            asalu_pkg::OP_ADD_LITERAL_ACCUM: begin
                next_res = sum_lit[7:0];
                {next_c, next_dc} = sum_lit[9:8];
                to_accum = 1'b1;
                {upd_c, upd_dc, upd_z} = 3'h7;
            end
            asalu_pkg::OP_AND_ACCUM_REGISTER: begin
                next_res = accum & mem_rdata;
                to_file  = cmd_d;
                to_accum = ~cmd_d;
                upd_z    = 1'b1;
            end
            asalu_pkg::OP_ADD_ACCUM_REGISTER: begin
                next_res = sum_reg[7:0];
                {next_c, next_dc} = sum_reg[9:8];
                to_file  = cmd_d;
                to_accum = ~cmd_d;
                {upd_c, upd_dc, upd_z} = 3'h7;
            end
            asalu_pkg::OP_ARITH_SHIFT_RIGHT: begin
                next_res = {mem_rdata[7], mem_rdata[7:1]};
                next_c   = mem_rdata[0];
                to_file  = cmd_d;
                to_accum = ~cmd_d;
                upd_c    = 1'b1;
                upd_z    = 1'b1;
            end
            asalu_pkg::OP_ADD_WITH_CARRY_REGISTER: begin
                next_res = sum_cry[7:0];
                {next_c, next_dc} = sum_cry[9:8];
                to_file  = cmd_d;
                to_accum = ~cmd_d;
                {upd_c, upd_dc, upd_z} = 3'h7;
            end
            default: begin
                next_res = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            accum <= `ASALU_ACCUM_RST;
        end else if (exec_go & to_accum) begin
            accum <= next_res;
        end else if (wr_go & (wb_adr_i == `ASALU_ADR_ACCUM) & wb_sel_i[0]) begin
            accum <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            last_res <= `ASALU_ACCUM_RST;
        end else if (exec_go & (to_accum | to_file)) begin
            last_res <= next_res;
        end
    end

    // Pointer add leaves flags untouched; sum wraps in 16 bits
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ptr0 <= `ASALU_PTR_RST;
            ptr1 <= `ASALU_PTR_RST;
        end else if (exec_go & (cmd_op == asalu_pkg::OP_POINTER_ADD_LITERAL)) begin
            if (cmd_n) begin
                ptr1 <= ptr1 + k_sext;
            end else begin
                ptr0 <= ptr0 + k_sext;
            end
        end else if (wr_go) begin
            if (wb_adr_i == `ASALU_ADR_PTR0) begin
                if (wb_sel_i[0]) ptr0[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) ptr0[15:8] <= wb_dat_i[15:8];
            end
            if (wb_adr_i == `ASALU_ADR_PTR1) begin
                if (wb_sel_i[0]) ptr1[7:0]  <= wb_dat_i[7:0];
                if (wb_sel_i[1]) ptr1[15:8] <= wb_dat_i[15:8];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            carry_flag       <= `ASALU_FLAG_RST;
            digit_carry_flag <= `ASALU_FLAG_RST;
            zero_flag        <= `ASALU_FLAG_RST;
        end else if (exec_go) begin
            if (upd_c) carry_flag <= next_c;
            if (upd_dc) digit_carry_flag <= next_dc;
            if (upd_z) zero_flag <= (next_res == 8'h00);
        end else if (wr_go & (wb_adr_i == `ASALU_ADR_STATUS) & wb_sel_i[0]) begin
            carry_flag       <= wb_dat_i[`ASALU_ST_C];
            digit_carry_flag <= wb_dat_i[`ASALU_ST_DC];
            zero_flag        <= wb_dat_i[`ASALU_ST_Z];
        end
    end

    // Checks
    logic ex_ptr0;
    logic ex_andl;
    logic ex_addl;
    logic ex_andr;
    logic ex_shr;
    logic ex_addc;
    logic ex_alu;
    assign ex_ptr0 = exec_go & ~cmd_n &
                     (cmd_op == asalu_pkg::OP_POINTER_ADD_LITERAL);
    assign ex_andl = exec_go & (cmd_op == asalu_pkg::OP_AND_LITERAL_ACCUM);
    assign ex_addl = exec_go & (cmd_op == asalu_pkg::OP_ADD_LITERAL_ACCUM);
    assign ex_andr = exec_go & (cmd_op == asalu_pkg::OP_AND_ACCUM_REGISTER);
    assign ex_shr  = exec_go & (cmd_op == asalu_pkg::OP_ARITH_SHIFT_RIGHT);
    assign ex_addc = exec_go &
                     (cmd_op == asalu_pkg::OP_ADD_WITH_CARRY_REGISTER);
    assign ex_alu  = exec_go & (cmd_op != asalu_pkg::OP_NONE) &
                     (cmd_op != asalu_pkg::OP_POINTER_ADD_LITERAL);

    property p_ptr_add;
        @(posedge clk_sys) disable iff (srst)
        ex_ptr0 |=> (32'(signed'(ptr0)) & 32'hFFFF) ==
            ((32'($past(ptr0)) + 32'(signed'($past(cmd_k[5:0])))) & 32'hFFFF);
    endproperty
    a_ptr_add: assert property (p_ptr_add)
        else $error("pointer add result wrong");

    property p_ptr_flags;
        @(posedge clk_sys) disable iff (srst)
        ex_ptr0 |=> $stable(carry_flag) && $stable(digit_carry_flag)
                    && $stable(zero_flag) && $stable(accum);
    endproperty
    a_ptr_flags: assert property (p_ptr_flags)
        else $error("pointer add changed flags");

    property p_ptr_wrap;
        @(posedge clk_sys) disable iff (srst)
        ex_ptr0 && ptr0 == `ASALU_PTR_MAX && cmd_k[5:0] == 6'h01
            |=> ptr0 == 16'h0000;
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap)
        else $error("pointer did not wrap");

    property p_and_lit;
        @(posedge clk_sys) disable iff (srst)
        ex_andl |=> accum == ($past(accum) & $past(cmd_k))
                    && $stable(carry_flag) && $stable(digit_carry_flag);
    endproperty
    a_and_lit: assert property (p_and_lit)
        else $error("literal and wrong");

    property p_add_lit;
        @(posedge clk_sys) disable iff (srst)
        ex_addl |=> {carry_flag, accum} ==
                    9'({1'b0, $past(accum)} + {1'b0, $past(cmd_k)});
    endproperty
    a_add_lit: assert property (p_add_lit)
        else $error("literal add wrong");

    property p_and_reg_dest;
        @(posedge clk_sys) disable iff (srst)
        ex_andr && cmd_d |=> $stable(accum) && $stable(carry_flag)
                             && last_res == ($past(accum) & $past(mem_rdata));
    endproperty
    a_and_reg_dest: assert property (p_and_reg_dest)
        else $error("register and wrote wrong place");

    property p_shift;
        @(posedge clk_sys) disable iff (srst)
        ex_shr |=> carry_flag == $past(mem_rdata[0])
                   && last_res[7] == $past(mem_rdata[7])
                   && last_res[6:0] == $past(mem_rdata[7:1]);
    endproperty
    a_shift: assert property (p_shift)
        else $error("arithmetic shift wrong");

    property p_addc;
        @(posedge clk_sys) disable iff (srst)
        ex_addc |=> {carry_flag, last_res} ==
            9'({1'b0, $past(accum)} + {1'b0, $past(mem_rdata)}
               + {8'h00, $past(carry_flag)});
    endproperty
    a_addc: assert property (p_addc)
        else $error("add with carry wrong");

    property p_one_cycle;
        @(posedge clk_sys) disable iff (srst)
        start |=> state == asalu_pkg::ST_FETCH ##1 exec_go
                  ##1 state == asalu_pkg::ST_IDLE;
    endproperty
    a_one_cycle: assert property (p_one_cycle)
        else $error("instruction cycle length wrong");

    property p_zero;
        @(posedge clk_sys) disable iff (srst)
        ex_alu |=> zero_flag == (last_res == 8'h00);
    endproperty
    a_zero: assert property (p_zero)
        else $error("zero flag wrong");

endmodule : asalu_top

/* File: asalu_wb_master.sv */
// Wishbone classic master model standing in for the core side
`timescale 1ns/1ps

module asalu_wb_master (
    // Clock
    input  wire logic        clk_sys,
    // Wishbone master
    output logic             wb_cyc_o,
    output logic             wb_stb_o,
    output logic             wb_we_o,
    output logic [11:0]      wb_adr_o,
    output logic [3:0]       wb_sel_o,
    output logic [31:0]      wb_dat_o,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic        wb_ack_i
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o  = 1'b0;
        wb_adr_o = 12'h000;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0000_0000;
    end

    // Request held until the acking edge, so a slow slave is safe
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= w;
        wb_adr_o <= a;
        wb_sel_o <= 4'hF;
        wb_dat_o <= d;
        do @(posedge clk_sys); while (wb_ack_i !== 1'b1);
        q = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o  <= 1'b0;
    endtask : xfer
endmodule : asalu_wb_master

/* File: asalu_top_tb_top.sv */
// Self-checking bench for the ALU block
`timescale 1ns/1ps
`include "asalu_consts.svh"

module asalu_top_tb_top;
    logic        clk_sys = 1'b0;
    logic        srst    = 1'b1;
    logic        wb_cyc, wb_stb, wb_we, wb_ack;
    logic [11:0] wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_wdat, wb_rdat;
    logic        busy, carry_flag, digit_carry_flag, zero_flag;
    int          failures    = 0;
    int          comparisons = 0;
    logic [31:0] exp_q[$];

    always #2.5 clk_sys = ~clk_sys;

    asalu_top asalu_top_i (
        .clk_sys(clk_sys), .srst(srst),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .busy(busy),
        .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
        .zero_flag(zero_flag));

    asalu_wb_master asalu_wb_master_i (
        .clk_sys(clk_sys), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb),
        .wb_we_o(wb_we), .wb_adr_o(wb_adr), .wb_sel_o(wb_sel),
        .wb_dat_o(wb_wdat), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack));

    task automatic end_sim;
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: read %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    // Read data is only valid in the acking cycle
    always @(posedge clk_sys) begin
        if (wb_ack === 1'b1 && wb_we === 1'b0) begin
            if (exp_q.size() == 0) begin
                failures++;
                $display("ERROR %0t: unexpected read answer", $time);
            end else
                cmp_word(wb_rdat, exp_q.pop_front());
        end
    end

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        asalu_wb_master_i.xfer(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        exp_q.push_back(e);
        asalu_wb_master_i.xfer(1'b0, a, 32'h0, q);
    endtask : rd

    // Reference result and flags {zero, digit carry, carry}
    function automatic void model(input logic [2:0] op,
        input logic [7:0] a, input logic [7:0] f, input logic [7:0] k,
        input logic [2:0] st, output logic [7:0] r, output logic [2:0] ns);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] b;
        logic       ci;
        ns = st;
        b  = (op == 3'h3) ? k : f;
        ci = (op == 3'h7) ? st[0] : 1'b0;
        s  = {1'b0, a} + {1'b0, b} + {8'h00, ci};
        h  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        case (op)
            3'h2: r = a & k;
            3'h4: r = a & f;
            3'h6: begin
                r     = {f[7], f[7:1]};
                ns[0] = f[0];
            end
            default: begin
                r     = s[7:0];
                ns[0] = s[8];
                ns[1] = h[4];
            end
        endcase
        ns[2] = (r == 8'h00);
    endfunction : model

    initial begin
        #200000;
        failures++;
        $display("ERROR %0t: timeout", $time);
        end_sim();
    end

    initial begin
        logic [7:0]  a, fv, k, r;
        logic [6:0]  f;
        logic [2:0]  st, ns;
        logic [11:0] fa;
        logic        dreg;
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        void'($urandom(53762));
        rd(`ASALU_ADR_ACCUM, 32'h0);
        rd(`ASALU_ADR_STATUS, 32'h0);
        rd(`ASALU_ADR_PTR0, 32'h0);
        wr(12'h020, 32'hFF);
        rd(12'h020, 32'h0);
        // Pointer wraps both ways, flags must survive
        wr(`ASALU_ADR_PTR0, 32'hFFFE);
        wr(`ASALU_ADR_STATUS, 32'h7);
        wr(`ASALU_ADR_EXEC, 32'h0000_0301);
        wr(`ASALU_ADR_EXEC, 32'h0000_2011);
        rd(`ASALU_ADR_PTR0, 32'h0001);
        rd(`ASALU_ADR_PTR1, 32'hFFE0);
        rd(`ASALU_ADR_STATUS, 32'h7);
        for (int i = 0; i < 4; i++)
            for (int op = 2; op <= 7; op++)
                for (int d = 0; d < 2; d++) begin
                    a  = 8'($urandom);
                    fv = 8'($urandom);
                    k  = 8'($urandom);
                    st = 3'($urandom);
                    f  = 7'($urandom);
                    // Sign bit set and sums that wrap to zero
                    if (i == 0) begin
                        a  = 8'h80;
                        fv = 8'h80;
                        k  = 8'h80;
                        f  = 7'd127;
                    end
                    model(op[2:0], a, fv, k, st, r, ns);
                    fa   = 12'h400 + {3'h0, f, 2'b00};
                    dreg = (d == 1) && (op >= 4);
                    wr(`ASALU_ADR_ACCUM, {24'h0, a});
                    wr(`ASALU_ADR_STATUS, {29'h0, st});
                    wr(fa, {24'h0, fv});
                    wr(`ASALU_ADR_EXEC,
                       {9'h0, f, k, 4'h0, d[0], op[2:0]});
                    rd(`ASALU_ADR_ACCUM, {24'h0, dreg ? a : r});
                    rd(fa, {24'h0, dreg ? r : fv});
                    rd(`ASALU_ADR_STATUS, {29'h0, ns});
                    rd(`ASALU_ADR_RESULT, {24'h0, r});
                end
        end_sim();
    end
endmodule : asalu_top_tb_top
